// ---- verilog/oaa_exec_unit.sv ----
`timescale 1ns/1ps
// Function
// - Direct mode uses 8-bit address field
// - Direct reaches internal RAM and SFRs only
// - Indirect takes address from named register
// - 8-bit pointer: register 0, 1 or stack
// - 16-bit pointer: data pointer only
// - Register mode: 3-bit field picks register
// - Bank chosen by two status bank bits
// - Specific mode implies target from opcode
// - Immediate operand follows opcode in code
// - Indexed mode reads program memory only
// - Indexed address is accumulator plus base
// - Add/subtract take direct, indirect, register, immediate
// - Increment modifies any internal byte
// - Data pointer increments as 16 bits
// - Multiply: high byte second, low accumulator
// - Divide: quotient accumulator, remainder second
// - Decimal adjust corrects after BCD addition
// - Banks are eight bytes from 00h
// - Overflow on signed range exit
// - Aux carry from bit 3
// - Parity set when ones count even
module oaa_exec_unit
	import oaa_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic opStart,
	input wire oaa_op_t opCode,
	input wire oaa_mode_t opMode,
	input wire logic [7:0] addrField,
	input wire logic [2:0] regField,
	input wire oaa_ptr_t ptrSel,
	input wire logic extSpace,
	input wire logic [7:0] immByte,
	input wire logic [7:0] stackPointer,
	input wire logic [15:0] progCounter,
	input wire logic [7:0] iramRdData,
	input wire logic [7:0] sfrRdData,
	input wire logic [7:0] xramRdData,
	input wire logic [7:0] codeRdData,
	output logic [7:0] iramAddr,
	output logic iramWe,
	output logic [7:0] iramWrData,
	output logic [7:0] sfrAddr,
	output logic sfrWe,
	output logic [7:0] sfrWrData,
	output logic [15:0] xramAddr,
	output logic xramRe,
	output logic [15:0] codeAddr,
	output logic codeRe,
	output logic opBusy,
	output logic opDone,
	output logic [7:0] accumulator,
	output logic [7:0] secondOperand,
	output logic [15:0] dataPointerPair,
	output logic [7:0] programStatusWord
);

	typedef enum logic [2:0] {
		OAA_ST_IDLE,
		OAA_ST_PTR,
		OAA_ST_FETCH,
		OAA_ST_EXEC,
		OAA_ST_DIVWAIT
	} oaa_state_t;

	oaa_state_t state_reg;
	oaa_op_t op_reg;
	oaa_mode_t mode_reg;
	logic [7:0] addr_reg;
	logic [2:0] regSel_reg;
	oaa_ptr_t ptr_reg;
	logic ext_reg;
	logic [7:0] imm_reg;
	logic [7:0] eaddr_reg;
	logic [7:0] operand_reg;
	logic [7:0] acc_reg;
	logic [7:0] second_reg;
	logic [15:0] dpair_reg;
	logic [7:0] stat_reg;
	logic done_reg;
	logic [7:0] bankBase;
	logic [7:0] fetched;
	logic [7:0] arithRes;
	logic arithCy;
	logic arithAc;
	logic arithOv;
	logic [15:0] product;
	logic [8:0] daLow;
	logic [8:0] daFull;
	logic divStart;
	logic divBusy;
	logic divDone;
	logic [7:0] divQuot;
	logic [7:0] divRem;
	logic isSfr;
	logic [7:0] memAddr;
	logic [7:0] secondEff;

	// ****************************************
	// Address resolution
	// ****************************************
	// Bank base from the two select bits, eight bytes per bank
	assign bankBase = {3'b000, stat_reg[OAA_STAT_BANK_HI], stat_reg[OAA_STAT_BANK_LO], 3'b000};

	// Upper half of the direct space is the SFR block; indirect never sees SFRs
	assign isSfr = (mode_reg == OAA_MODE_DIRECT) && (eaddr_reg >= OAA_SFR_BASE);

	// First stage address: register slot, pointer register slot or direct field
	always_comb begin
		memAddr = addr_reg;
		if (mode_reg == OAA_MODE_REGISTER) begin
			memAddr = bankBase | {5'b00000, regSel_reg};
		end else if (mode_reg == OAA_MODE_INDIRECT) begin
			memAddr = bankBase | {7'b0000000, ptr_reg == OAA_PTR_REG_ONE};
		end
	end

	// Operand seen in fetch state, by source
	always_comb begin
		fetched = iramRdData;
		if (mode_reg == OAA_MODE_IMMEDIATE) begin
			fetched = imm_reg;
		end else if (isSfr) begin
			fetched = sfrRdData;
		end else if (mode_reg == OAA_MODE_INDIRECT && ext_reg) begin
			fetched = xramRdData;
		end
	end

	// Memory strobes; only increment writes back to memory
	always_comb begin
		iramAddr = (state_reg == OAA_ST_PTR) ? memAddr : eaddr_reg;
		iramWe = 1'b0;
		iramWrData = operand_reg + 8'h01;
		sfrAddr = eaddr_reg;
		sfrWe = 1'b0;
		sfrWrData = operand_reg + 8'h01;
		xramAddr = (ptr_reg == OAA_PTR_PAIR) ? dpair_reg : {8'h00, eaddr_reg};
		xramRe = (state_reg == OAA_ST_FETCH) && (mode_reg == OAA_MODE_INDIRECT) && ext_reg;
		// Indexed fetch is a read strobe only; no write path exists to code space
		codeRe = (state_reg == OAA_ST_FETCH) && (mode_reg == OAA_MODE_INDEXED);
		codeAddr = ((op_reg == OAA_OP_MOVC_PC) ? progCounter : dpair_reg)
			+ {8'h00, acc_reg};
		if (state_reg == OAA_ST_EXEC && op_reg == OAA_OP_INC_MEM) begin
			iramWe = !isSfr;
			sfrWe = isSfr;
		end
	end

	// ****************************************
	// Arithmetic helpers
	// ****************************************
	oaa_add_sub u_add_sub (
		.opA(acc_reg),
		.opB(operand_reg),
		.carryIn((op_reg == OAA_OP_ADD) ? 1'b0 : stat_reg[OAA_STAT_CARRY]),
		.subtract(op_reg == OAA_OP_SUB_BORROW),
		.result(arithRes),
		.carryOut(arithCy),
		.auxCarry(arithAc),
		.overflow(arithOv)
	);

	oaa_divider #(
		.WIDTH(OAA_DATA_W)
	) u_divider (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.start(divStart),
		.dividend(acc_reg),
		.divisor(secondEff),
		.busy(divBusy),
		.done(divDone),
		.quotient(divQuot),
		.remainder(divRem)
	);

	// Fetched byte stands in for the second register, which has no load port
	assign secondEff = (mode_reg == OAA_MODE_SPECIFIC) ? second_reg : operand_reg;
	assign product = acc_reg * secondEff;
	// Zero divisor skips the divider; results are undefined anyway
	assign divStart = (state_reg == OAA_ST_EXEC) && (op_reg == OAA_OP_DIV)
		&& (secondEff != 8'h00);

	// Decimal adjust, two steps; only meaningful after a BCD add
	always_comb begin
		daLow = {1'b0, acc_reg};
		if (acc_reg[3:0] > 4'h9 || stat_reg[OAA_STAT_AUX]) begin
			daLow = {1'b0, acc_reg} + 9'h006;
		end
		daFull = daLow;
		if (daLow[7:4] > 4'h9 || daLow[8] || stat_reg[OAA_STAT_CARRY]) begin
			daFull = daLow + 9'h060;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= OAA_ST_IDLE;
			op_reg <= OAA_OP_NONE;
			mode_reg <= OAA_MODE_SPECIFIC;
			addr_reg <= 8'h00;
			regSel_reg <= 3'b000;
			ptr_reg <= OAA_PTR_REG_ZERO;
			ext_reg <= 1'b0;
			imm_reg <= 8'h00;
			eaddr_reg <= 8'h00;
			operand_reg <= 8'h00;
		end else begin
			case (state_reg)
				OAA_ST_IDLE: begin
					if (opStart) begin
						op_reg <= opCode;
						mode_reg <= opMode;
						addr_reg <= addrField;
						regSel_reg <= regField;
						ptr_reg <= ptrSel;
						ext_reg <= extSpace;
						imm_reg <= immByte;
						eaddr_reg <= addrField;
						// Specific ops have no operand fetch at all
						state_reg <= (opMode == OAA_MODE_SPECIFIC) ? OAA_ST_EXEC
							: (opMode == OAA_MODE_INDIRECT || opMode == OAA_MODE_REGISTER)
							? OAA_ST_PTR : OAA_ST_FETCH;
					end
				end
				OAA_ST_PTR: begin
					// Register mode: slot is the operand address; indirect: read pointer
					eaddr_reg <= memAddr;
					if (mode_reg == OAA_MODE_INDIRECT) begin
						eaddr_reg <= (ptr_reg == OAA_PTR_STACK) ? stackPointer
							: iramRdData;
					end
					state_reg <= OAA_ST_FETCH;
				end
				OAA_ST_FETCH: begin
					operand_reg <= (mode_reg == OAA_MODE_INDEXED) ? codeRdData : fetched;
					state_reg <= OAA_ST_EXEC;
				end
				OAA_ST_EXEC: begin
					state_reg <= divStart ? OAA_ST_DIVWAIT : OAA_ST_IDLE;
				end
				OAA_ST_DIVWAIT: begin
					if (divDone) begin
						state_reg <= OAA_ST_IDLE;
					end
				end
				default: begin
					state_reg <= OAA_ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Architectural registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_reg <= OAA_ACC_RST;
			second_reg <= OAA_SECOND_RST;
			dpair_reg <= OAA_DPAIR_RST;
			stat_reg <= OAA_STAT_RST;
		end else begin
			if (state_reg == OAA_ST_EXEC) begin
				case (op_reg)
					OAA_OP_ADD, OAA_OP_ADD_CARRY, OAA_OP_SUB_BORROW: begin
						acc_reg <= arithRes;
						stat_reg[OAA_STAT_CARRY] <= arithCy;
						stat_reg[OAA_STAT_AUX] <= arithAc;
						stat_reg[OAA_STAT_OVF] <= arithOv;
					end
					OAA_OP_INC_ACC: begin
						acc_reg <= acc_reg + 8'h01;
					end
					OAA_OP_INC_PAIR: begin
						dpair_reg <= dpair_reg + 16'h0001;
					end
					OAA_OP_MUL: begin
						acc_reg <= product[7:0];
						second_reg <= product[15:8];
						stat_reg[OAA_STAT_CARRY] <= 1'b0;
						stat_reg[OAA_STAT_OVF] <= (product[15:8] != 8'h00);
					end
					OAA_OP_DIV: begin
						stat_reg[OAA_STAT_CARRY] <= 1'b0;
						stat_reg[OAA_STAT_OVF] <= (secondEff == 8'h00);
					end
					OAA_OP_DA: begin
						acc_reg <= daFull[7:0];
						stat_reg[OAA_STAT_CARRY] <= stat_reg[OAA_STAT_CARRY] | daFull[8];
					end
					OAA_OP_MOVC_PAIR, OAA_OP_MOVC_PC: begin
						acc_reg <= operand_reg;
					end
					default: begin
						acc_reg <= acc_reg;
					end
				endcase
			end
			if (divDone) begin
				acc_reg <= divQuot;
				second_reg <= divRem;
			end
			// Parity tracks the accumulator continuously
			stat_reg[OAA_STAT_PARITY] <= ~^acc_reg;
		end
	end

	// Completion pulse, one cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= ((state_reg == OAA_ST_EXEC) && !divStart) || divDone;
		end
	end

	assign opBusy = (state_reg != OAA_ST_IDLE);
	assign opDone = done_reg;
	assign accumulator = acc_reg;
	assign secondOperand = second_reg;
	assign dataPointerPair = dpair_reg;
	assign programStatusWord = stat_reg;

endmodule // oaa_exec_unit

// ---- verilog/oaa_pkg.sv ----
package oaa_pkg;

	// ****************************************
	// Widths and address map
	// ****************************************
	localparam int OAA_DATA_W = 8;
	localparam int OAA_ADDR16_W = 16;
	localparam logic [7:0] OAA_SFR_BASE = 8'h80;
	localparam logic [7:0] OAA_BANK_STRIDE = 8'h08;
	localparam int OAA_BANK_SEL_LSB = 3;
	localparam int OAA_STAT_CARRY = 7;
	localparam int OAA_STAT_AUX = 6;
	localparam int OAA_STAT_BANK_HI = 4;
	localparam int OAA_STAT_BANK_LO = 3;
	localparam int OAA_STAT_OVF = 2;
	localparam int OAA_STAT_PARITY = 0;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] OAA_ACC_RST = 8'h00;
	localparam logic [7:0] OAA_SECOND_RST = 8'h00;
	localparam logic [7:0] OAA_STAT_RST = 8'h00;
	localparam logic [15:0] OAA_DPAIR_RST = 16'h0000;
	localparam int OAA_DIV_CYCLES = 8;

	// ****************************************
	// Operand addressing modes
	// ****************************************
	typedef enum logic [2:0] {
		OAA_MODE_DIRECT,
		OAA_MODE_INDIRECT,
		OAA_MODE_REGISTER,
		OAA_MODE_SPECIFIC,
		OAA_MODE_IMMEDIATE,
		OAA_MODE_INDEXED
	} oaa_mode_t;

	// Indirect pointer choice
	typedef enum logic [1:0] {
		OAA_PTR_REG_ZERO,
		OAA_PTR_REG_ONE,
		OAA_PTR_STACK,
		OAA_PTR_PAIR
	} oaa_ptr_t;

	// Operations
	typedef enum logic [3:0] {
		OAA_OP_NONE,
		OAA_OP_ADD,
		OAA_OP_ADD_CARRY,
		OAA_OP_SUB_BORROW,
		OAA_OP_INC_ACC,
		OAA_OP_INC_MEM,
		OAA_OP_INC_PAIR,
		OAA_OP_MUL,
		OAA_OP_DIV,
		OAA_OP_DA,
		OAA_OP_MOVC_PAIR,
		OAA_OP_MOVC_PC
	} oaa_op_t;

endpackage

// ---- verilog/oaa_add_sub.sv ----
`timescale 1ns/1ps
// Byte adder/subtractor with carry, aux carry and signed overflow
module oaa_add_sub
	import oaa_pkg::*;
(
	input wire logic [7:0] opA,
	input wire logic [7:0] opB,
	input wire logic carryIn,
	input wire logic subtract,
	output logic [7:0] result,
	output logic carryOut,
	output logic auxCarry,
	output logic overflow
);

	logic [4:0] lowNibble;
	logic [8:0] full;
	logic [7:0] opBEff;

	// ****************************************
	// Datapath
	// ****************************************
	// Subtract is done as add of complement; a nibble carry then means no borrow from bit 4
	always_comb begin
		opBEff = subtract ? ~opB : opB;
		lowNibble = {1'b0, opA[3:0]} + {1'b0, opBEff[3:0]} + {4'h0, carryIn ^ subtract};
		full = {1'b0, opA} + {1'b0, opBEff} + {8'h00, carryIn ^ subtract};
		result = full[7:0];
		carryOut = subtract ? ~full[8] : full[8];
		auxCarry = lowNibble[4];
		overflow = (opA[7] == opBEff[7]) && (result[7] != opA[7]);
	end

endmodule // oaa_add_sub

// ---- verilog/oaa_divider.sv ----
`timescale 1ns/1ps
// Restoring 8/8 divider, one quotient bit per clock
module oaa_divider
	import oaa_pkg::*;
#(
	parameter int WIDTH = OAA_DATA_W
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [WIDTH-1:0] dividend,
	input wire logic [WIDTH-1:0] divisor,
	output logic busy,
	output logic done,
	output logic [WIDTH-1:0] quotient,
	output logic [WIDTH-1:0] remainder
);

	logic [WIDTH-1:0] quot_reg;
	logic [WIDTH:0] rem_reg;
	logic [WIDTH-1:0] dvsr_reg;
	logic [3:0] count_reg;
	logic busy_reg;
	logic done_reg;
	logic [WIDTH:0] trial;

	// Trial subtraction of the shifted partial remainder
	always_comb begin
		trial = {rem_reg[WIDTH-1:0], quot_reg[WIDTH-1]} - {1'b0, dvsr_reg};
	end

	// ****************************************
	// Iteration
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			quot_reg <= '0;
			rem_reg <= '0;
			dvsr_reg <= '0;
			count_reg <= 4'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (start && !busy_reg) begin
				quot_reg <= dividend;
				rem_reg <= '0;
				dvsr_reg <= divisor;
				count_reg <= 4'(WIDTH);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (!trial[WIDTH]) begin
					rem_reg <= trial;
					quot_reg <= {quot_reg[WIDTH-2:0], 1'b1};
				end else begin
					rem_reg <= {rem_reg[WIDTH-1:0], quot_reg[WIDTH-1]};
					quot_reg <= {quot_reg[WIDTH-2:0], 1'b0};
				end
				count_reg <= count_reg - 4'h1;
				if (count_reg == 4'h1) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
	assign quotient = quot_reg;
	assign remainder = rem_reg[WIDTH-1:0];

endmodule // oaa_divider

// ---- test/oaa_mem_model.sv ----
`timescale 1ns/1ps
// Internal RAM, SFR, external RAM and code memory behind the unit
module oaa_mem_model
	import oaa_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] iramAddr,
	input wire logic iramWe,
	input wire logic [7:0] iramWrData,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWe,
	input wire logic [7:0] sfrWrData,
	input wire logic [15:0] xramAddr,
	input wire logic xramRe,
	input wire logic [15:0] codeAddr,
	input wire logic codeRe,
	output logic [7:0] iramRdData,
	output logic [7:0] sfrRdData,
	output logic [7:0] xramRdData,
	output logic [7:0] codeRdData
);
	logic [7:0] iram [256];
	logic [7:0] sfr [256];
	logic [7:0] xramVal;
	logic [7:0] codeVal;
	// Seed with a pattern the bench can predict
	initial begin
		for (int i = 0; i < 256; i++) begin
			iram[i] = 8'(i) ^ 8'hC3;
			sfr[i] = 8'(i) ^ 8'hC3;
		end
	end
	// Writes land on the clock edge
	always @(posedge sys_clk) begin
		if (iramWe)
			iram[iramAddr] <= iramWrData;
		if (sfrWe)
			sfr[sfrAddr] <= sfrWrData;
	end
	// Unstrobed external and code reads show inverted data so stale values never pass
	assign xramVal = xramAddr[7:0] ^ 8'hA5;
	assign codeVal = codeAddr[7:0] ^ codeAddr[15:8] ^ 8'h5A;
	assign iramRdData = iram[iramAddr];
	assign sfrRdData = sfr[sfrAddr];
	assign xramRdData = xramRe ? xramVal : ~xramVal;
	assign codeRdData = codeRe ? codeVal : ~codeVal;
endmodule // oaa_mem_model

// ---- test/oaa_exec_monitor.sv ----
`timescale 1ns/1ps
// Port-level checks on the execution unit
module oaa_exec_monitor
	import oaa_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic opStart,
	input wire logic opBusy,
	input wire logic opDone,
	input wire oaa_mode_t opMode,
	input wire logic [7:0] addrField,
	input wire logic [2:0] regField,
	input wire oaa_ptr_t ptrSel,
	input wire logic [15:0] progCounter,
	input wire logic [7:0] iramAddr,
	input wire logic iramWe,
	input wire logic [7:0] iramWrData,
	input wire logic [7:0] iramRdData,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWe,
	input wire logic [15:0] xramAddr,
	input wire logic xramRe,
	input wire logic [15:0] codeAddr,
	input wire logic codeRe,
	input wire logic [7:0] accumulator,
	input wire logic [15:0] dataPointerPair,
	input wire logic [7:0] programStatusWord
);
	// ****
	// Properties
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_take;
		opStart && !opBusy;
	endsequence
	sequence s_take_in(oaa_mode_t m);
		opStart && !opBusy && opMode == m;
	endsequence
	property p_answer;
		s_take |-> ##[2:13] opDone;
	endproperty
	a_answer: assert property (p_answer) else $error("no done in time");
	property p_direct;
		s_take_in(OAA_MODE_DIRECT) |=> ($past(addrField) < OAA_SFR_BASE) ?
			(iramAddr == $past(addrField)) : (sfrAddr == $past(addrField));
	endproperty
	a_direct: assert property (p_direct) else $error("direct address");
	property p_sfr_high;
		sfrWe |-> sfrAddr >= OAA_SFR_BASE;
	endproperty
	a_sfr_high: assert property (p_sfr_high) else $error("sfr write low");
	property p_reg;
		s_take_in(OAA_MODE_REGISTER) |=>
			iramAddr == {3'b000, programStatusWord[4:3], $past(regField)};
	endproperty
	a_reg: assert property (p_reg) else $error("register slot");
	property p_ptr;
		s_take_in(OAA_MODE_INDIRECT) ##0 (ptrSel == OAA_PTR_REG_ZERO || ptrSel == OAA_PTR_REG_ONE) |=>
			iramAddr == {3'b000, programStatusWord[4:3], 2'b00, $past(ptrSel[0])};
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer slot");
	property p_ext;
		xramRe |-> xramAddr == dataPointerPair || xramAddr[15:8] == 8'h00;
	endproperty
	a_ext: assert property (p_ext) else $error("external address");
	property p_index;
		codeRe |-> !iramWe && !sfrWe && (codeAddr == dataPointerPair + accumulator ||
			codeAddr == progCounter + accumulator);
	endproperty
	a_index: assert property (p_index) else $error("indexed read");
	property p_inc_mem;
		iramWe |-> iramWrData == iramRdData + 8'h01;
	endproperty
	a_inc_mem: assert property (p_inc_mem) else $error("increment data");
	property p_dpair;
		$changed(dataPointerPair) |-> dataPointerPair == $past(dataPointerPair) + 16'h0001;
	endproperty
	a_dpair: assert property (p_dpair) else $error("pointer step");
	property p_parity;
		$changed(accumulator) |=> programStatusWord[OAA_STAT_PARITY] == ~^$past(accumulator);
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag");
endmodule // oaa_exec_monitor

bind oaa_exec_unit oaa_exec_monitor oaa_exec_monitor_inst (.*);

// ---- test/test_operand_addressing_arith_unit.sv ----
`timescale 1ns/1ps
// Directed bench for the execution unit
module test_operand_addressing_arith_unit
	import oaa_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic opStart = 1'b0;
	oaa_op_t opCode = OAA_OP_NONE;
	oaa_mode_t opMode = OAA_MODE_DIRECT;
	logic [7:0] addrField = 8'h00;
	logic [2:0] regField = 3'h0;
	oaa_ptr_t ptrSel = OAA_PTR_REG_ZERO;
	logic extSpace = 1'b0;
	logic [7:0] iramRdData, sfrRdData, xramRdData, codeRdData, iramAddr, iramWrData;
	logic [7:0] sfrAddr, sfrWrData, accumulator, secondOperand, programStatusWord;
	logic iramWe, sfrWe, xramRe, codeRe, opBusy, opDone;
	logic [15:0] xramAddr, codeAddr, dataPointerPair;
	int mismatches = 0;
	int checks = 0;

	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	// Immediate shares the address field; stack and PC are fixed
	oaa_exec_unit oaa_exec_unit_inst (.*, .immByte(addrField), .stackPointer(8'h30),
		.progCounter(16'h1234));
	oaa_mem_model oaa_mem_model_inst (.*);

	// ****
	// Tasks
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One operation; returns one edge after done so parity has settled
	task automatic op(input oaa_op_t c, input oaa_mode_t m, input logic [7:0] a = 8'h00,
		input logic [2:0] r = 3'h0, input oaa_ptr_t p = OAA_PTR_REG_ZERO, input logic x = 1'b0);
		int n;
		@(negedge sys_clk);
		opCode = c;
		opMode = m;
		addrField = a;
		regField = r;
		ptrSel = p;
		extSpace = x;
		opStart = 1'b1;
		@(negedge sys_clk);
		opStart = 1'b0;
		n = 0;
		while (opDone !== 1'b1 && n < 40) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 40)
			mismatches++;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic give_verdict();
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end

	// Directed sequence
	initial begin
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		@(posedge sys_clk);
		#1;
		chk(programStatusWord, 8'h01);
		op(OAA_OP_ADD, OAA_MODE_IMMEDIATE, 8'h7F);
		chk({accumulator, programStatusWord}, 16'h7F00);
		op(OAA_OP_ADD, OAA_MODE_DIRECT, 8'hC2);
		chk({accumulator, programStatusWord}, 16'h8044);
		op(OAA_OP_ADD, OAA_MODE_REGISTER, 8'h00, 3'h2);
		chk({accumulator, programStatusWord}, 16'h4185);
		op(OAA_OP_ADD_CARRY, OAA_MODE_INDIRECT);
		chk({accumulator, programStatusWord}, 16'h4201);
		op(OAA_OP_SUB_BORROW, OAA_MODE_IMMEDIATE, 8'h43);
		chk({accumulator, programStatusWord}, 16'hFF81);
		op(OAA_OP_INC_ACC, OAA_MODE_SPECIFIC);
		chk({accumulator, programStatusWord}, 16'h0081);
		op(OAA_OP_ADD, OAA_MODE_IMMEDIATE, 8'h19);
		op(OAA_OP_ADD, OAA_MODE_IMMEDIATE, 8'h28);
		chk({accumulator, programStatusWord}, 16'h4141);
		op(OAA_OP_DA, OAA_MODE_SPECIFIC);
		chk(accumulator, 8'h47);
		op(OAA_OP_DIV, OAA_MODE_SPECIFIC);
		chk({accumulator, secondOperand}, 16'h4700);
		chk({programStatusWord[7], programStatusWord[2]}, 16'h0001);
		op(OAA_OP_MUL, OAA_MODE_SPECIFIC);
		chk({accumulator, secondOperand}, 16'h0000);
		chk({programStatusWord[7], programStatusWord[2]}, 16'h0000);
		op(OAA_OP_INC_MEM, OAA_MODE_DIRECT, 8'h50);
		op(OAA_OP_INC_MEM, OAA_MODE_DIRECT, 8'h90);
		chk({oaa_mem_model_inst.iram[80], oaa_mem_model_inst.sfr[144]}, 16'h9454);
		repeat (255) op(OAA_OP_INC_PAIR, OAA_MODE_SPECIFIC);
		chk(dataPointerPair, 16'h00FF);
		op(OAA_OP_INC_PAIR, OAA_MODE_SPECIFIC);
		chk(dataPointerPair, 16'h0100);
		op(OAA_OP_MOVC_PAIR, OAA_MODE_INDEXED);
		chk(accumulator, 8'h5B);
		op(OAA_OP_MOVC_PC, OAA_MODE_INDEXED);
		chk(accumulator, 8'hC7);
		op(OAA_OP_ADD, OAA_MODE_INDIRECT, 8'h00, 3'h0, OAA_PTR_PAIR, 1'b1);
		chk(accumulator, 8'h6C);
		op(OAA_OP_ADD, OAA_MODE_INDIRECT, 8'h00, 3'h0, OAA_PTR_STACK);
		chk(accumulator, 8'h5F);
		op(OAA_OP_ADD_CARRY, OAA_MODE_INDIRECT, 8'h00, 3'h0, OAA_PTR_REG_ONE);
		chk(accumulator, 8'h61);
		op(OAA_OP_ADD, OAA_MODE_INDIRECT, 8'h00, 3'h0, OAA_PTR_REG_ZERO, 1'b1);
		chk(accumulator, 8'hC7);
		op(OAA_OP_MUL, OAA_MODE_IMMEDIATE, 8'h03);
		chk({accumulator, secondOperand}, 16'h5502);
		chk({programStatusWord[7], programStatusWord[2]}, 16'h0001);
		op(OAA_OP_DIV, OAA_MODE_IMMEDIATE, 8'h09);
		chk({accumulator, secondOperand}, 16'h0904);
		chk({programStatusWord[7], programStatusWord[2]}, 16'h0000);
		op(OAA_OP_DIV, OAA_MODE_SPECIFIC);
		chk({accumulator, secondOperand}, 16'h0201);
		give_verdict();
	end
endmodule // test_operand_addressing_arith_unit
